// ---- hdl/mmx_pkg.sv ----
// Shared types and constants of the min/max, multiply and linked-load unit.
// Assumes a single-issue slot fed by the core's decode and register read.
package mmx_pkg;

    // ****************************************************************
    // Widths and constants
    // ****************************************************************
    localparam int XLEN = 32;
    localparam int BRW  = 4;
    localparam int PAW  = 40;
    localparam int IMMW = 9;
    localparam int GRW  = 6;
    localparam int BIW  = 3;
    localparam int HALF = 16;

    localparam logic [GRW-1:0]  LINK_REG       = 6'h3F;
    localparam logic [BRW-1:0]  PRED_FALSE     = 4'h0;
    localparam logic [PAW-1:0]  LINK_ADDR_MASK = 40'hFF_FFFF_FFE0;
    localparam logic [1:0]      LOCK_SET       = 2'h3;
    localparam logic [1:0]      LOCK_CLEAR     = 2'h0;
    localparam logic [1:0]      WORD_ALIGNED   = 2'h0;
    // Control-register window; placement is a plain default
    localparam logic [XLEN-1:0] CREG_MASK      = 32'hFFFF_0000;
    localparam logic [XLEN-1:0] CREG_BASE      = 32'hFFFF_0000;

    // ****************************************************************
    // Operations and exception codes
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_NONE  = 4'b0000,
        OP_LDWC  = 4'b0001,
        OP_LDWL  = 4'b0010,
        OP_MIN   = 4'b0011,
        OP_MAX   = 4'b0100,
        OP_MINU  = 4'b0101,
        OP_MAXU  = 4'b0110,
        OP_MINPH = 4'b0111,
        OP_MAXPH = 4'b1000,
        OP_MOVBB = 4'b1001,
        OP_MOVBR = 4'b1010,
        OP_MOVRB = 4'b1011,
        OP_MULPH = 4'b1100,
        OP_MULLO = 4'b1101
    } mmx_op_t;

    typedef enum logic [2:0] {
        EXC_NONE                 = 3'b000,
        EXC_DATA_BREAKPOINT      = 3'b001,
        EXC_DATA_TRANSLATION     = 3'b010,
        EXC_CONTROL_SPACE_VIOL   = 3'b011,
        EXC_UNMAPPED_CONTROL_REG = 3'b100,
        EXC_MISALIGNMENT         = 3'b101
    } mmx_exc_code_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic            valid;
        mmx_op_t         op;
        logic [XLEN-1:0] src1;
        logic [XLEN-1:0] src2;
        logic [IMMW-1:0] imm;
        logic            use_imm;
        logic [BRW-1:0]  bsrc;
        logic [GRW-1:0]  dest;
        logic [BIW-1:0]  bdest;
    } mmx_issue_t;

    typedef struct packed {
        logic            valid;
        logic [GRW-1:0]  dest;
        logic [XLEN-1:0] data;
    } mmx_gwb_t;

    typedef struct packed {
        logic           valid;
        logic [BIW-1:0] idx;
        logic [BRW-1:0] value;
    } mmx_bwb_t;

    typedef struct packed {
        logic          valid;
        mmx_exc_code_t code;
    } mmx_exc_t;

    typedef struct packed {
        logic            valid;
        logic [XLEN-1:0] addr;
        logic            creg;
    } mmx_mreq_t;

    typedef struct packed {
        mmx_gwb_t       fast_wb;
        mmx_bwb_t       breg_wb;
        mmx_bwb_t       breg_branch_wb;
        logic           ld_pend;
        logic [GRW-1:0] ld_dest;
        mmx_gwb_t       mul_pend;
        mmx_gwb_t       slow_wb;
        mmx_exc_t       exc;
        mmx_mreq_t      mem_req;
        logic [1:0]     lock;
        logic [PAW-1:0] link_addr;
    } mmx_state_t;

endpackage

// ---- hdl/mmx_alu.sv ----
// Combinational min/max, branch-to-general move and multipliers.
// Assumes the caller registers the results to give the issue latency.
`timescale 1ns/100ps

module mmx_alu #(
    parameter int XLEN = mmx_pkg::XLEN,
    parameter int IMMW = mmx_pkg::IMMW
) (
    // Operation and operands
    input  wire mmx_pkg::mmx_op_t  i_op,
    input  wire logic [XLEN-1:0]   i_src1,
    input  wire logic [XLEN-1:0]   i_src2,
    input  wire logic [IMMW-1:0]   i_imm,
    input  wire logic              i_use_imm,
    input  wire logic [3:0]        i_bsrc,
    // Results
    output logic      [XLEN-1:0]   o_result,
    output logic      [XLEN-1:0]   o_product
);

    localparam int H = mmx_pkg::HALF;

    function automatic logic [XLEN-1:0] sext_imm(input logic [IMMW-1:0] v);
        sext_imm = {{(XLEN-IMMW){v[IMMW-1]}}, v};
    endfunction

    function automatic logic [XLEN-1:0] zext_imm(input logic [IMMW-1:0] v);
        zext_imm = {{(XLEN-IMMW){1'b0}}, v};
    endfunction

    logic [XLEN-1:0]   opnd_s;
    logic [XLEN-1:0]   opnd_u;
    logic              lt_s;
    logic              lt_u;
    logic [XLEN-1:0]   lane_min;
    logic [XLEN-1:0]   lane_max;
    logic [XLEN-1:0]   lane_mul;
    logic [2*XLEN-1:0] mul_full;

    // Signed forms sign-extend the immediate, unsigned ones zero-extend
    assign opnd_s = i_use_imm ? sext_imm(i_imm) : i_src2;  // [RULE10]
    assign opnd_u = i_use_imm ? zext_imm(i_imm) : i_src2;  // [RULE10]
    assign lt_s   = $signed(i_src1) < $signed(opnd_s);     // [RULE10]
    assign lt_u   = i_src1 < opnd_u;                       // [RULE10]

    genvar j;
    generate
        for (j = 0; j < XLEN / H; j++) begin : g_lane
            logic signed [H-1:0]   a;
            logic signed [H-1:0]   b;
            logic signed [2*H-1:0] p;
            assign a = i_src1[j*H +: H];
            assign b = i_src2[j*H +: H];
            assign p = a * b;
            assign lane_min[j*H +: H] = (a < b) ? a : b;   // [RULE13]
            assign lane_max[j*H +: H] = (a > b) ? a : b;   // [RULE12]
            assign lane_mul[j*H +: H] = p[H-1:0];          // [RULE18]
        end
    endgenerate

    // Low word is the same for signed and unsigned readings
    assign mul_full = $signed(i_src1) * $signed(opnd_s);   // [RULE19]

    always_comb begin
        o_product = mul_full[XLEN-1:0];                    // [RULE19]
        if (i_op == mmx_pkg::OP_MULPH) begin
            o_product = lane_mul;
        end
    end

    always_comb begin
        case (i_op)
            mmx_pkg::OP_MIN:   o_result = lt_s ? i_src1 : opnd_s;
            mmx_pkg::OP_MAX:   o_result = lt_s ? opnd_s : i_src1;
            mmx_pkg::OP_MINU:  o_result = lt_u ? i_src1 : opnd_u;
            mmx_pkg::OP_MAXU:  o_result = lt_u ? opnd_u : i_src1;
            mmx_pkg::OP_MINPH: o_result = lane_min;
            mmx_pkg::OP_MAXPH: o_result = lane_max;
            mmx_pkg::OP_MOVRB: o_result = {{(XLEN-4){1'b0}}, i_bsrc}; // [RULE17]
            default:           o_result = i_src1;
        endcase
    end

endmodule

// ---- hdl/mmx_unit.sv ----
// Execution unit: conditional and linked word loads, min/max, branch
// register moves and multiplies, with reservation state.
// Assumes TLB, breakpoint and control-register checks answer in the
// issue cycle from o_ea, and memory returns read data in the next cycle.
`timescale 1ns/100ps

// What this block does and what it expects of the program
// [RULE1] Conditional load result readable two cycles later
// [RULE2] Program spaces link-register jump three cycles
// [RULE3] Conditional load raises only five exception kinds
// [RULE4] Program never predicates on branch register zero
// [RULE5] Program issues one load/store-unit operation per bundle
// [RULE6] Linked load uses bare address, sets lock
// [RULE7] Linked load records masked translated reservation address
// [RULE8] Breakpoint first, then control-space violation
// [RULE9] Program never targets link register there
// [RULE10] Min/max with signed or unsigned immediate
// [RULE11] Min/max results forward after one cycle
// [RULE12] Packed maximum per signed 16-bit lane
// [RULE13] Packed minimum per signed 16-bit lane
// [RULE14] Branch-to-branch move copies four bits
// [RULE15] General-to-branch move keeps low four bits
// [RULE16] Branch ops see moved value two cycles
// [RULE17] Branch-to-general move zero-extends to 32 bits
// [RULE18] Packed multiply keeps low 16 bits
// [RULE19] Word multiply keeps low 32 product bits
// [RULE20] Program places multiplies at odd addresses
// [RULE21] Multiply result readable two cycles later
// [RULE22] False predicate: no access, exception, write
module mmx_unit (
    // Clock and reset
    input  wire logic                       i_clock,
    input  wire logic                       i_sys_rst,
    // Issue slot
    input  wire mmx_pkg::mmx_issue_t        i_issue,
    // Address checks, answered in the issue cycle
    input  wire logic [mmx_pkg::PAW-1:0]    i_phys_addr,
    input  wire logic                       i_tlb_fault,
    input  wire logic                       i_bkpt_hit,
    input  wire logic                       i_creg_unmapped,
    input  wire logic                       i_creg_priv_fault,
    output logic      [mmx_pkg::XLEN-1:0]   o_ea,
    // Memory path
    output mmx_pkg::mmx_mreq_t              o_mem_req,
    input  wire logic [mmx_pkg::XLEN-1:0]   i_mem_rdata,
    // Reservation
    input  wire logic                       i_lock_clear,
    output logic      [1:0]                 o_lock,
    output logic      [mmx_pkg::PAW-1:0]    o_link_addr,
    // Results
    output mmx_pkg::mmx_gwb_t               o_fast_wb,
    output mmx_pkg::mmx_gwb_t               o_slow_wb,
    output mmx_pkg::mmx_bwb_t               o_breg_wb,
    output mmx_pkg::mmx_bwb_t               o_breg_branch_wb,
    output mmx_pkg::mmx_exc_t               o_exc
);

    // ****************************************************************
    // Issue decode
    // ****************************************************************
    mmx_pkg::mmx_state_t     st;
    mmx_pkg::mmx_state_t     next_st;
    logic [mmx_pkg::XLEN-1:0] alu_result;
    logic [mmx_pkg::XLEN-1:0] product;
    logic                     is_ldwc;
    logic                     is_ldwl;
    logic                     ld_go;
    logic                     in_creg;
    mmx_pkg::mmx_exc_code_t   fault;

    function automatic logic is_alu(input mmx_pkg::mmx_op_t op);
        is_alu = (op == mmx_pkg::OP_MIN)   || (op == mmx_pkg::OP_MAX)   ||
                 (op == mmx_pkg::OP_MINU)  || (op == mmx_pkg::OP_MAXU)  ||
                 (op == mmx_pkg::OP_MINPH) || (op == mmx_pkg::OP_MAXPH) ||
                 (op == mmx_pkg::OP_MOVRB);
    endfunction

    function automatic logic is_mul(input mmx_pkg::mmx_op_t op);
        is_mul = (op == mmx_pkg::OP_MULPH) || (op == mmx_pkg::OP_MULLO);
    endfunction

    function automatic logic is_bmove(input mmx_pkg::mmx_op_t op);
        is_bmove = (op == mmx_pkg::OP_MOVBB) || (op == mmx_pkg::OP_MOVBR);
    endfunction

    mmx_alu u_alu (
        .i_op      (i_issue.op),
        .i_src1    (i_issue.src1),
        .i_src2    (i_issue.src2),
        .i_imm     (i_issue.imm),
        .i_use_imm (i_issue.use_imm),
        .i_bsrc    (i_issue.bsrc),
        .o_result  (alu_result),
        .o_product (product)
    );

    assign is_ldwc = i_issue.valid && (i_issue.op == mmx_pkg::OP_LDWC);
    assign is_ldwl = i_issue.valid && (i_issue.op == mmx_pkg::OP_LDWL);
    // A false predicate turns the load into nothing at all
    assign ld_go   = is_ldwl ||
                     (is_ldwc && (i_issue.bsrc != mmx_pkg::PRED_FALSE)); // [RULE22]

    // Linked load takes the register as is; conditional adds the offset
    always_comb begin
        if (i_issue.op == mmx_pkg::OP_LDWL) begin
            o_ea = i_issue.src1;                                // [RULE6]
        end else begin
            o_ea = i_issue.src1 + {{(mmx_pkg::XLEN-mmx_pkg::IMMW)
                   {i_issue.imm[mmx_pkg::IMMW-1]}}, i_issue.imm};
        end
    end

    assign in_creg = (o_ea & mmx_pkg::CREG_MASK) == mmx_pkg::CREG_BASE;

    // Breakpoint wins over everything; the linked load may never touch
    // control space, the conditional load may read it when mapped
    always_comb begin
        fault = mmx_pkg::EXC_NONE;
        if (i_bkpt_hit) begin
            fault = mmx_pkg::EXC_DATA_BREAKPOINT;               // [RULE8]
        end else if (in_creg && is_ldwl) begin
            fault = mmx_pkg::EXC_CONTROL_SPACE_VIOL;            // [RULE8]
        end else if (in_creg && i_creg_priv_fault) begin
            fault = mmx_pkg::EXC_CONTROL_SPACE_VIOL;            // [RULE3]
        end else if (in_creg && i_creg_unmapped) begin
            fault = mmx_pkg::EXC_UNMAPPED_CONTROL_REG;          // [RULE3]
        end else if (o_ea[1:0] != mmx_pkg::WORD_ALIGNED) begin
            fault = mmx_pkg::EXC_MISALIGNMENT;                  // [RULE3]
        end else if (!in_creg && i_tlb_fault) begin
            fault = mmx_pkg::EXC_DATA_TRANSLATION;              // [RULE3]
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.fast_wb.valid  = 1'b0;
        next_st.breg_wb.valid  = 1'b0;
        next_st.ld_pend        = 1'b0;
        next_st.mul_pend.valid = 1'b0;
        next_st.slow_wb.valid  = 1'b0;
        next_st.exc            = '{1'b0, mmx_pkg::EXC_NONE};
        next_st.mem_req.valid  = 1'b0;

        // One-cycle results for min/max and branch-to-general
        if (i_issue.valid && is_alu(i_issue.op)) begin
            next_st.fast_wb = '{1'b1, i_issue.dest, alu_result}; // [RULE11]
        end

        // General consumers see a moved branch value after one cycle,
        // conditional branches one cycle later again
        if (i_issue.valid && is_bmove(i_issue.op)) begin
            next_st.breg_wb.valid = 1'b1;
            next_st.breg_wb.idx   = i_issue.bdest;
            if (i_issue.op == mmx_pkg::OP_MOVBB) begin
                next_st.breg_wb.value = i_issue.bsrc;            // [RULE14]
            end else begin
                next_st.breg_wb.value = i_issue.src1[3:0];       // [RULE15]
            end
        end
        next_st.breg_branch_wb = st.breg_wb;                     // [RULE16]

        if (i_issue.valid && is_mul(i_issue.op)) begin
            next_st.mul_pend = '{1'b1, i_issue.dest, product};   // [RULE21]
        end

        if (ld_go) begin
            if (fault != mmx_pkg::EXC_NONE) begin
                next_st.exc = '{1'b1, fault};                    // [RULE3]
            end else begin
                next_st.mem_req = '{1'b1, o_ea, in_creg};
                next_st.ld_pend = 1'b1;
                next_st.ld_dest = i_issue.dest;
            end
        end

        // Reservation is only recorded once the access has checked out
        if (is_ldwl && (fault == mmx_pkg::EXC_NONE)) begin
            next_st.link_addr = i_phys_addr &
                                mmx_pkg::LINK_ADDR_MASK;         // [RULE7]
        end
        // The lock is taken before any check; a set beats a clear
        if (is_ldwl) begin
            next_st.lock = mmx_pkg::LOCK_SET;                    // [RULE6]
        end else if (i_lock_clear) begin
            next_st.lock = mmx_pkg::LOCK_CLEAR;
        end

        // Second stage: load data or multiply product retire here
        if (st.ld_pend) begin
            next_st.slow_wb = '{1'b1, st.ld_dest, i_mem_rdata};  // [RULE1]
        end else if (st.mul_pend.valid) begin
            next_st.slow_wb = st.mul_pend;                       // [RULE21]
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_fast_wb        = st.fast_wb;
    assign o_slow_wb        = st.slow_wb;
    assign o_breg_wb        = st.breg_wb;
    assign o_breg_branch_wb = st.breg_branch_wb;
    assign o_exc            = st.exc;
    assign o_mem_req        = st.mem_req;
    assign o_lock           = st.lock;
    assign o_link_addr      = st.link_addr;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    logic ldwc_ok;
    logic ldwc_off;
    assign ldwc_ok  = is_ldwc && ld_go && (fault == mmx_pkg::EXC_NONE);
    assign ldwc_off = is_ldwc && !ld_go;

    sequence s_req_then_wb(logic [5:0] d);
        o_mem_req.valid ##1 (o_slow_wb.valid && o_slow_wb.dest == d);
    endsequence

    sequence s_breg_two_step(logic [2:0] b);
        (o_breg_wb.valid && o_breg_wb.idx == b && !o_breg_branch_wb.valid)
        ##1 (o_breg_branch_wb.valid && o_breg_branch_wb.idx == b);
    endsequence

    property p_ldwc_lat;
        logic [5:0] d;
        (ldwc_ok, d = i_issue.dest) |=> s_req_then_wb(d);
    endproperty
    a_ldwc_lat: assert property (p_ldwc_lat)     // [RULE1]
        else $error("conditional load result not at two cycles");

    property p_exc_kinds;
        o_exc.valid |-> o_exc.code inside {
            mmx_pkg::EXC_DATA_BREAKPOINT, mmx_pkg::EXC_DATA_TRANSLATION,
            mmx_pkg::EXC_CONTROL_SPACE_VIOL,
            mmx_pkg::EXC_UNMAPPED_CONTROL_REG, mmx_pkg::EXC_MISALIGNMENT}
            && !o_mem_req.valid;
    endproperty
    a_exc_kinds: assert property (p_exc_kinds)   // [RULE3]
        else $error("illegal exception code or access with exception");

    property p_ldwl_lock;
        is_ldwl && !i_bkpt_hit && !in_creg && !i_tlb_fault
            && (i_issue.src1[1:0] == mmx_pkg::WORD_ALIGNED)
        |=> o_lock == mmx_pkg::LOCK_SET
            && o_mem_req.addr == $past(i_issue.src1);
    endproperty
    a_ldwl_lock: assert property (p_ldwl_lock)   // [RULE6]
        else $error("linked load lock or address wrong");

    property p_link_addr;
        is_ldwl && fault == mmx_pkg::EXC_NONE |=>
            o_link_addr == ($past(i_phys_addr) & mmx_pkg::LINK_ADDR_MASK);
    endproperty
    a_link_addr: assert property (p_link_addr)   // [RULE7]
        else $error("reservation address not recorded");

    property p_bkpt_first;
        ld_go && i_bkpt_hit |=>
            o_exc.valid && o_exc.code == mmx_pkg::EXC_DATA_BREAKPOINT;
    endproperty
    a_bkpt_first: assert property (p_bkpt_first)   // [RULE8]
        else $error("breakpoint did not take priority");

    property p_alu_lat;
        i_issue.valid && is_alu(i_issue.op) |=>
            o_fast_wb.valid && o_fast_wb.dest == $past(i_issue.dest);
    endproperty
    a_alu_lat: assert property (p_alu_lat)       // [RULE11]
        else $error("min/max result not forwarded after one cycle");

    property p_breg_lat;
        logic [2:0] b;
        (i_issue.valid && is_bmove(i_issue.op), b = i_issue.bdest)
            |=> s_breg_two_step(b);
    endproperty
    a_breg_lat: assert property (p_breg_lat)     // [RULE16]
        else $error("branch register move timing wrong");

    property p_mul_lat;
        i_issue.valid && is_mul(i_issue.op) |=> !o_slow_wb.valid
            ##1 (o_slow_wb.valid && o_slow_wb.data == $past(product, 2));
    endproperty
    a_mul_lat: assert property (p_mul_lat)       // [RULE21]
        else $error("multiply result not at two cycles");

    property p_pred_false;
        ldwc_off |=> !o_mem_req.valid && !o_exc.valid ##1 !o_slow_wb.valid;
    endproperty
    a_pred_false: assert property (p_pred_false) // [RULE22]
        else $error("false predicate caused an access or write");

endmodule

// ---- tb/mmx_mem_model.sv ----
// Far-side model: address checks and load data for the execution unit.
// Assumes checks answer combinationally from the effective address.
`timescale 1ns/100ps

module mmx_mem_model (
    // Clock and request side
    input  wire logic               i_clock,
    input  wire logic [31:0]        i_ea,
    input  wire mmx_pkg::mmx_mreq_t i_req,
    // Answers
    output logic      [39:0]        o_phys_addr,
    output logic                    o_tlb_fault,
    output logic                    o_bkpt_hit,
    output logic                    o_creg_unmapped,
    output logic                    o_creg_priv_fault,
    output logic      [31:0]        o_rdata
);
    logic [31:0] junk = 32'h5A5A_A5A5;

    // Fault windows are fixed so the bench can aim at each one
    assign o_phys_addr       = {8'h01, i_ea};
    assign o_bkpt_hit        = i_ea[31:8] == 24'h00000B;
    assign o_tlb_fault       = i_ea[31:12] == 20'h0000D;
    assign o_creg_unmapped   = i_ea[31:8] == 24'hFFFFEE;
    assign o_creg_priv_fault = i_ea[31:8] == 24'hFFFFAA;

    // Outside a request the data toggles, so no stale word can pass
    always @(posedge i_clock) begin
        junk <= ~junk;
    end
    assign o_rdata = i_req.valid ? ~i_req.addr : junk;
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the min/max, multiply and linked-load unit.
// Assumes the far-side model answers checks in the issue cycle.
`timescale 1ns/100ps

module tb;
    logic                i_clock      = 1'b0;
    logic                i_sys_rst    = 1'b1;
    logic                i_lock_clear = 1'b0;
    mmx_pkg::mmx_issue_t iss          = '0;
    logic [39:0]         phys, link;
    logic                tlb, dbk, unm, prv;
    logic [31:0]         ea, rdata;
    logic [1:0]          lock, c1_lock;
    mmx_pkg::mmx_mreq_t  req, c1_req;
    mmx_pkg::mmx_gwb_t   fwb, swb, c1_fwb, c1_swb, c2_swb;
    mmx_pkg::mmx_bwb_t   bwb, bbwb, c1_bwb, c1_bbwb, c2_bbwb;
    mmx_pkg::mmx_exc_t   exc, c1_exc;
    int                  n_mismatch = 0;
    int                  tests_run  = 0;

    mmx_unit mmx_unit_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_issue(iss), .i_phys_addr(phys), .i_tlb_fault(tlb),
        .i_bkpt_hit(dbk), .i_creg_unmapped(unm),
        .i_creg_priv_fault(prv), .o_ea(ea), .o_mem_req(req),
        .i_mem_rdata(rdata), .i_lock_clear(i_lock_clear), .o_lock(lock),
        .o_link_addr(link), .o_fast_wb(fwb), .o_slow_wb(swb),
        .o_breg_wb(bwb), .o_breg_branch_wb(bbwb), .o_exc(exc));
    mmx_mem_model mmx_mem_model_i (.i_clock(i_clock), .i_ea(ea),
        .i_req(req), .o_phys_addr(phys), .o_tlb_fault(tlb),
        .o_bkpt_hit(dbk), .o_creg_unmapped(unm),
        .o_creg_priv_fault(prv), .o_rdata(rdata));

    always #5 i_clock = ~i_clock;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic stop_test;
        $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic run(input mmx_pkg::mmx_op_t op, input logic [31:0] s1,
                       input logic [31:0] s2, input logic [8:0] imm,
                       input logic ui, input logic [3:0] bs);
        @(posedge i_clock);
        // Never the link register, one op a cycle
        iss <= {1'b1, op, s1, s2, imm, ui, bs, 6'h05, 3'h5};
        @(posedge i_clock);
        iss.valid <= 1'b0;
        #1;
        c1_fwb  = fwb;
        c1_swb  = swb;
        c1_bwb  = bwb;
        c1_bbwb = bbwb;
        c1_exc  = exc;
        c1_req  = req;
        c1_lock = lock;
        @(posedge i_clock);
        #1;
        c2_swb  = swb;
        c2_bbwb = bbwb;
    endtask

    task automatic t_minmax;
        mmx_pkg::mmx_op_t ops [4] = '{mmx_pkg::OP_MIN, mmx_pkg::OP_MAX,
                                      mmx_pkg::OP_MINU, mmx_pkg::OP_MAXU};
        logic [31:0] er [4] = '{32'hFFFF_FFFE, 32'h5, 32'h5, 32'hFFFF_FFFE};
        logic [31:0] ei [4] = '{32'hFFFF_FFFF, 32'h3, 32'h3, 32'h1FF};
        for (int k = 0; k < 4; k++) begin
            run(ops[k], 32'hFFFF_FFFE, 32'h5, 9'h000, 1'b0, 4'h0);
            chk(c1_fwb, {1'b1, 6'h05, er[k]});
            run(ops[k], 32'h3, 32'h0, 9'h1FF, 1'b1, 4'h0);
            chk(c1_fwb.data, ei[k]);
        end
        run(mmx_pkg::OP_MAXPH, 32'h8000_7FFF, 32'h0001_FFFF, 9'h0, 0, 0);
        chk(c1_fwb.data, 32'h0001_7FFF);
        run(mmx_pkg::OP_MINPH, 32'h8000_7FFF, 32'h0001_FFFF, 9'h0, 0, 0);
        chk(c1_fwb.data, 32'h8000_FFFF);
    endtask

    task automatic t_mul;
        run(mmx_pkg::OP_MULPH, 32'h0003_FFFF, 32'h0004_0002, 9'h0, 0, 0);
        chk({c1_fwb.valid, c1_swb.valid}, 2'b00);
        chk(c2_swb, {1'b1, 6'h05, 32'h000C_FFFE});
        run(mmx_pkg::OP_MULLO, 32'h0001_0003, 32'h0002_0005, 9'h0, 0, 0);
        chk(c2_swb.data, 32'h000B_000F);
        run(mmx_pkg::OP_MULLO, 32'h5, 32'h0, 9'h1FE, 1'b1, 4'h0);
        chk(c2_swb.data, 32'hFFFF_FFF6);
    endtask

    task automatic t_moves;
        run(mmx_pkg::OP_MOVBB, 32'h0, 32'h0, 9'h0, 0, 4'hA);
        chk(c1_bwb, {1'b1, 3'h5, 4'hA});
        chk(c1_bbwb.valid, 1'b0);
        chk(c2_bbwb, {1'b1, 3'h5, 4'hA});
        run(mmx_pkg::OP_MOVBR, 32'h1234_567B, 32'h0, 9'h0, 0, 4'h0);
        chk(c1_bwb, {1'b1, 3'h5, 4'hB});
        chk(c2_bbwb, {1'b1, 3'h5, 4'hB});
        run(mmx_pkg::OP_MOVRB, 32'hFFFF_FFFF, 32'h0, 9'h0, 0, 4'h9);
        chk(c1_fwb, {1'b1, 6'h05, 32'h9});
    endtask

    task automatic t_loads;
        logic [31:0] ad [6] = '{32'hB00, 32'hB02, 32'hFFFF_AA00,
                                32'hFFFF_EE00, 32'h102, 32'hD000};
        mmx_pkg::mmx_exc_code_t cd [6] = '{mmx_pkg::EXC_DATA_BREAKPOINT,
            mmx_pkg::EXC_DATA_BREAKPOINT, mmx_pkg::EXC_CONTROL_SPACE_VIOL,
            mmx_pkg::EXC_UNMAPPED_CONTROL_REG, mmx_pkg::EXC_MISALIGNMENT,
            mmx_pkg::EXC_DATA_TRANSLATION};
        run(mmx_pkg::OP_LDWC, 32'h100, 32'h0, 9'h004, 1'b1, 4'h1);
        chk(c1_req, {1'b1, 32'h104, 1'b0});
        chk(c1_exc.valid, 1'b0);
        chk(c2_swb, {1'b1, 6'h05, 32'hFFFF_FEFB});
        run(mmx_pkg::OP_LDWC, 32'h100, 32'h0, 9'h004, 1'b1, 4'h0);
        chk({c1_req.valid, c1_exc.valid, c2_swb.valid}, 3'b000);
        run(mmx_pkg::OP_LDWC, 32'hFFFF_0100, 32'h0, 9'h0, 1'b1, 4'h2);
        chk(c1_req, {1'b1, 32'hFFFF_0100, 1'b1});
        for (int k = 0; k < 6; k++) begin
            run(mmx_pkg::OP_LDWC, ad[k], 32'h0, 9'h0, 1'b1, 4'h2);
            chk({c1_exc, c1_req.valid, c2_swb.valid},
                {1'b1, cd[k], 2'b00});
        end
        run(mmx_pkg::OP_LDWL, 32'h25C, 32'h0, 9'h010, 1'b1, 4'h0);
        chk(c1_req, {1'b1, 32'h25C, 1'b0});
        chk({lock, link}, {2'h3, 40'h01_0000_0240});
        chk(c2_swb.data, 32'hFFFF_FDA3);
        @(posedge i_clock);
        i_lock_clear <= 1'b1;
        @(posedge i_clock);
        #1;
        chk(lock, 2'h0);
        // Clear still high on the issue edge: the set must win
        run(mmx_pkg::OP_LDWL, 32'hFFFF_0040, 32'h0, 9'h0, 1'b0, 4'h0);
        chk(c1_exc, {1'b1, mmx_pkg::EXC_CONTROL_SPACE_VIOL});
        chk({c1_lock, link}, {2'h3, 40'h01_0000_0240});
        @(posedge i_clock);
        i_lock_clear <= 1'b0;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        #1;
        chk({lock, link, fwb.valid, swb.valid}, '0);
        t_minmax();
        t_mul();
        t_moves();
        t_loads();
        stop_test();
    end
endmodule
